// ==== hdl/pte_pkg.sv ====
package pte_pkg;
  localparam int unsigned AXI_AW   = 12;
  localparam int unsigned PAT_W    = 32;
  localparam int unsigned LEN_W    = 5;
  localparam int unsigned RATE_W   = 4;
  localparam int unsigned DIV_W    = 16;
  localparam int unsigned LOOP_W   = 16;
  localparam int unsigned MODE_W   = 2;

  // global registers
  localparam logic [11:0] OFF_ENABLE  = 12'h000;
  localparam logic [11:0] OFF_START   = 12'h004;
  localparam logic [11:0] OFF_STOP    = 12'h008;
  localparam logic [11:0] OFF_CLKSEL  = 12'h00c;
  localparam logic [11:0] OFF_DONE    = 12'h010;
  localparam logic [11:0] OFF_ALTFN   = 12'h014;
  localparam logic [11:0] OFF_RUNNING = 12'h018;
  // per-generator blocks of four words
  localparam logic [11:0] OFF_CH_BASE = 12'h040;
  localparam int unsigned CH_SHIFT    = 4;
  localparam logic [1:0]  FLD_CFG     = 2'h0;
  localparam logic [1:0]  FLD_PATTERN = 2'h1;
  localparam logic [1:0]  FLD_LOOPS   = 2'h2;
  localparam logic [1:0]  FLD_RESTART = 2'h3;

  localparam int unsigned CFG_MODE_LSB = 0;
  localparam int unsigned CFG_LEN_LSB  = 8;
  localparam int unsigned CFG_RATE_LSB = 16;

  localparam logic [31:0] RST_CFG     = 32'h0000_1f00;
  localparam logic [31:0] RST_PATTERN = 32'h0000_0000;
  localparam logic [31:0] RST_LOOPS   = 32'h0000_0000;
  localparam logic [31:0] RST_RESTART = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_SQUARE, MODE_PATTERN, MODE_SINGLE} mode_t;
endpackage

// ==== hdl/chan_if.sv ====
interface chan_if;
  logic                           start;
  logic                           stop;
  logic                           tick;
  logic [pte_pkg::MODE_W-1:0]     mode;
  logic [pte_pkg::LEN_W-1:0]      len_m1;
  logic [pte_pkg::RATE_W-1:0]     rate;
  logic [pte_pkg::PAT_W-1:0]      pattern;
  logic [pte_pkg::LOOP_W-1:0]     loops;
  logic                           running;
  logic                           done;
  logic                           out;

  modport ctl (output start, stop, tick, mode, len_m1, rate, pattern, loops,
               input running, done, out);
  modport gen (input start, stop, tick, mode, len_m1, rate, pattern, loops,
               output running, done, out);
endinterface

// ==== hdl/pte_tick_src.sv ====
module pte_tick_src (
  input  wire logic clk,     // module clock
  input  wire logic rst_n,   // synchronous reset, active low
  input  wire logic alt_clk, // separate rate source, asynchronous
  input  wire logic sel,     // 1 selects the separate source
  output logic      tick     // advance strobe for all generators
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= alt_clk;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // separate source must stay below half the module clock to be seen
  assign tick = sel ? (sync_q & ~prev_q) : 1'b1;
endmodule

// ==== hdl/pte_channel.sv ====
module pte_channel (
  input  wire logic clk,   // module clock
  input  wire logic rst_n, // synchronous reset, active low
  chan_if.gen       c      // configuration in, status out
);
  typedef enum logic {CH_IDLE, CH_RUN} state_t;

  state_t                      state_q;
  logic [pte_pkg::DIV_W-1:0]   div_q;
  logic [pte_pkg::LEN_W-1:0]   idx_q;
  logic [pte_pkg::LOOP_W-1:0]  loop_q;
  logic                        stop_pend_q;
  logic                        out_q;
  logic                        done_q;
  pte_pkg::mode_t              m;
  logic [16:0]                 lim_full;
  logic                        is_square;
  logic                        bit_end;
  logic [pte_pkg::LEN_W-1:0]   last_idx;
  logic [pte_pkg::LEN_W-1:0]   next_idx;
  logic                        loop_end;
  logic                        finite_end;

  assign m         = pte_pkg::mode_t'(c.mode);
  assign is_square = !(m == pte_pkg::MODE_PATTERN || m == pte_pkg::MODE_SINGLE);
  assign lim_full  = (17'h1 << ({1'b0, c.rate} + 5'h1)) - 17'h1;
  assign bit_end   = (state_q == CH_RUN) && c.tick && (div_q == lim_full[15:0]);
  // a one-bit length is widened to the shortest legal pattern of two
  assign last_idx  = (c.len_m1 == 5'h0) ? 5'h1 : c.len_m1;
  assign next_idx  = (idx_q == last_idx) ? 5'h0 : idx_q + 5'h1;
  assign loop_end  = bit_end && !is_square && (idx_q == last_idx);
  assign finite_end = loop_end && ((m == pte_pkg::MODE_SINGLE) ||
                      (c.loops != 16'h0 && loop_q + 16'h1 == c.loops));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q     <= CH_IDLE;
      div_q       <= 16'h0;
      idx_q       <= 5'h0;
      loop_q      <= 16'h0;
      stop_pend_q <= 1'b0;
      out_q       <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        CH_IDLE: begin
          stop_pend_q <= 1'b0;
          if (c.start) begin
            state_q <= CH_RUN;
            div_q   <= 16'h0;
            idx_q   <= 5'h0;
            loop_q  <= 16'h0;
            out_q   <= is_square ? 1'b1 : c.pattern[0];
          end
        end
        CH_RUN: begin
          if (c.start) begin
            stop_pend_q <= 1'b0;
            div_q       <= 16'h0;
            idx_q       <= 5'h0;
            loop_q      <= 16'h0;
            out_q       <= is_square ? 1'b1 : c.pattern[0];
          end else begin
            if (c.stop) begin
              stop_pend_q <= 1'b1;
            end
            if (c.tick) begin
              div_q <= bit_end ? 16'h0 : div_q + 16'h1;
            end
            // stopping waits for a bit boundary so no partial bit is cut off
            if (bit_end && (stop_pend_q || finite_end)) begin
              state_q <= CH_IDLE;
              out_q   <= 1'b0;
              done_q  <= finite_end && !stop_pend_q;
            end else if (bit_end && is_square) begin
              out_q <= ~out_q;
            end else if (bit_end) begin
              idx_q  <= next_idx;
              out_q  <= c.pattern[next_idx];
              loop_q <= loop_end ? loop_q + 16'h1 : loop_q;
            end
          end
        end
        default: state_q <= CH_IDLE;
      endcase
    end
  end

  assign c.running = (state_q == CH_RUN);
  assign c.out     = out_q;
  assign c.done    = done_q;

  sequence s_finish;
    bit_end && finite_end && !stop_pend_q && !c.start;
  endsequence
  sequence s_idle_low;
    (state_q == CH_IDLE) && !out_q && done_q;
  endsequence

  chk_finish_idle: assert property (@(posedge clk) disable iff (!rst_n)
    s_finish |=> s_idle_low) else $error("finished generator not idle and low");
  chk_start_lsb: assert property (@(posedge clk) disable iff (!rst_n)
    c.start |=> out_q == (is_square ? 1'b1 : $past(c.pattern[0])))
    else $error("first output bit wrong after start");
  chk_no_partial: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == CH_RUN) && !bit_end && !c.start |=> (state_q == CH_RUN) && $stable(out_q))
    else $error("output changed or stopped inside a bit");
  chk_endless_loop: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == CH_RUN) && c.loops == 16'h0 && m == pte_pkg::MODE_PATTERN &&
    !stop_pend_q && !c.stop ##1 !c.stop [*2] |-> (state_q == CH_RUN))
    else $error("indefinite pattern stopped");
endmodule

// ==== hdl/pulse_train_engine.sv ====
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
module pulse_train_engine #(
  parameter int unsigned NUM_CH = 2
) (
  input  wire logic              REF_CLK,  // module clock, 200 MHz
  input  wire logic              RST_N,    // synchronous reset, active low
  input  wire logic              ALT_CLK,  // separate rate source
  input  wire logic [NUM_CH-1:0] GPIO_OUT, // ordinary pin values
  output logic      [NUM_CH-1:0] PIN_OUT,  // muxed pin drive
  input  wire logic [11:0]       AWADDR,   // write address
  input  wire logic              AWVALID,  // write address valid
  output logic                   AWREADY,  // write address ready
  input  wire logic [31:0]       WDATA,    // write data
  input  wire logic [3:0]        WSTRB,    // write byte enables
  input  wire logic              WVALID,   // write data valid
  output logic                   WREADY,   // write data ready
  output logic [1:0]             BRESP,    // write response
  output logic                   BVALID,   // write response valid
  input  wire logic              BREADY,   // write response ready
  input  wire logic [11:0]       ARADDR,   // read address
  input  wire logic              ARVALID,  // read address valid
  output logic                   ARREADY,  // read address ready
  output logic [31:0]            RDATA,    // read data
  output logic [1:0]             RRESP,    // read response
  output logic                   RVALID,   // read data valid
  input  wire logic              RREADY    // read data ready
);
  logic              aw_full_q;
  logic [11:0]       aw_addr_q;
  logic              w_full_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic              wr_do;
  logic              wr_ok;
  logic [31:0]       wmask;
  logic [31:0]       rd_data;
  logic              rd_ok;

  logic [NUM_CH-1:0] enable_q;
  logic [NUM_CH-1:0] en_d;
  logic              clksel_q;
  logic [NUM_CH-1:0] altfn_q;
  logic [NUM_CH-1:0] done_q;
  logic [NUM_CH-1:0] done_clr;
  logic [NUM_CH-1:0] start_wr;
  logic [NUM_CH-1:0] stop_wr;
  logic [NUM_CH-1:0] restart_vec;
  logic [NUM_CH-1:0] start_vec;
  logic [NUM_CH-1:0] stop_vec;
  logic [NUM_CH-1:0] pin_q;
  logic [31:0]       cfg_q     [NUM_CH];
  logic [31:0]       pat_q     [NUM_CH];
  logic [31:0]       loops_q   [NUM_CH];
  logic [31:0]       rstmask_q [NUM_CH];
  logic              tick;
  wire  [NUM_CH-1:0] ch_run;
  wire  [NUM_CH-1:0] ch_out;
  wire  [NUM_CH-1:0] ch_done;

  function automatic logic is_ch(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - pte_pkg::OFF_CH_BASE;
    return (a >= pte_pkg::OFF_CH_BASE) && ((rel >> pte_pkg::CH_SHIFT) < 12'(NUM_CH));
  endfunction

  function automatic logic [7:0] ch_idx(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - pte_pkg::OFF_CH_BASE;
    return rel[11:4];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    return (old_v & ~m) | (new_v & m);
  endfunction

  pte_tick_src u_tick (
    .clk     (REF_CLK),
    .rst_n   (RST_N),
    .alt_clk (ALT_CLK),
    .sel     (clksel_q),
    .tick    (tick)
  );

  // ---- axi4-lite write side: address and data taken in either order
  assign aw_take = AWVALID && awready_q;
  assign w_take  = WVALID && wready_q;
  assign wr_do   = aw_full_q && w_full_q && !bvalid_q;
  assign wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 12'h0;
      awready_q <= 1'b0;
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      wready_q  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end else if (wr_do) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
      end else if (wr_do) begin
        w_full_q <= 1'b0;
      end
      awready_q <= !(aw_take || (aw_full_q && !wr_do));
      wready_q  <= !(w_take || (w_full_q && !wr_do));
    end
  end

  always_comb begin
    wr_ok = is_ch(aw_addr_q);
    case ({aw_addr_q[11:2], 2'b00})
      pte_pkg::OFF_ENABLE, pte_pkg::OFF_START, pte_pkg::OFF_STOP, pte_pkg::OFF_CLKSEL,
      pte_pkg::OFF_DONE, pte_pkg::OFF_ALTFN, pte_pkg::OFF_RUNNING: wr_ok = 1'b1;
      default: ;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      bvalid_q <= 1'b0;
      bresp_q  <= pte_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? pte_pkg::RESP_OKAY : pte_pkg::RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---- write effects on the global registers
  always_comb begin
    logic [31:0] wm;
    wm       = w_data_q & wmask;
    en_d     = enable_q;
    start_wr = '0;
    stop_wr  = '0;
    done_clr = '0;
    if (wr_do) begin
      case ({aw_addr_q[11:2], 2'b00})
        pte_pkg::OFF_ENABLE: en_d = (enable_q & ~wmask[NUM_CH-1:0]) | wm[NUM_CH-1:0];
        pte_pkg::OFF_START:  start_wr = wm[NUM_CH-1:0];
        pte_pkg::OFF_STOP:   stop_wr = wm[NUM_CH-1:0];
        pte_pkg::OFF_DONE:   done_clr = wm[NUM_CH-1:0];
        default: ;
      endcase
    end
  end

  // loop termination of one generator fans out to its chosen partners
  always_comb begin
    restart_vec = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_done[i]) begin
        restart_vec = restart_vec | rstmask_q[i][NUM_CH-1:0];
      end
    end
  end

  // one write of several start bits lines the generators up on one edge
  assign start_vec = ((en_d & ~enable_q) | start_wr | restart_vec) & en_d;
  assign stop_vec  = (enable_q & ~en_d) | stop_wr;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      enable_q <= '0;
      clksel_q <= 1'b0;
      altfn_q  <= '0;
    end else begin
      enable_q <= en_d;
      if (wr_do && {aw_addr_q[11:2], 2'b00} == pte_pkg::OFF_CLKSEL && w_strb_q[0]) begin
        clksel_q <= w_data_q[0];
      end
      if (wr_do && {aw_addr_q[11:2], 2'b00} == pte_pkg::OFF_ALTFN) begin
        altfn_q <= (altfn_q & ~wmask[NUM_CH-1:0]) | (w_data_q[NUM_CH-1:0] & wmask[NUM_CH-1:0]);
      end
    end
  end

  // a completion in the same cycle as its clear stays set
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      done_q <= '0;
    end else begin
      done_q <= ch_done | (done_q & ~done_clr);
    end
  end

  // ---- per-generator configuration, each word owned by one generator
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cfg_q[i]     <= pte_pkg::RST_CFG;
        pat_q[i]     <= pte_pkg::RST_PATTERN;
        loops_q[i]   <= pte_pkg::RST_LOOPS;
        rstmask_q[i] <= pte_pkg::RST_RESTART;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_do && is_ch(aw_addr_q) && ch_idx(aw_addr_q) == 8'(i)) begin
          case (aw_addr_q[3:2])
            pte_pkg::FLD_CFG:     cfg_q[i]     <= merge(cfg_q[i], w_data_q, wmask);
            pte_pkg::FLD_PATTERN: pat_q[i]     <= merge(pat_q[i], w_data_q, wmask);
            pte_pkg::FLD_LOOPS:   loops_q[i]   <= merge(loops_q[i], w_data_q, wmask);
            pte_pkg::FLD_RESTART: rstmask_q[i] <= merge(rstmask_q[i], w_data_q, wmask);
            default: ;
          endcase
        end
      end
    end
  end

  // ---- generators
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    chan_if cif ();
    assign cif.start   = start_vec[g];
    assign cif.stop    = stop_vec[g];
    assign cif.tick    = tick;
    assign cif.mode    = cfg_q[g][pte_pkg::CFG_MODE_LSB +: pte_pkg::MODE_W];
    assign cif.len_m1  = cfg_q[g][pte_pkg::CFG_LEN_LSB +: pte_pkg::LEN_W];
    assign cif.rate    = cfg_q[g][pte_pkg::CFG_RATE_LSB +: pte_pkg::RATE_W];
    assign cif.pattern = pat_q[g];
    assign cif.loops   = loops_q[g][pte_pkg::LOOP_W-1:0];
    assign ch_run[g]   = cif.running;
    assign ch_out[g]   = cif.out;
    assign ch_done[g]  = cif.done;

    pte_channel u_ch (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .c     (cif)
    );

    chk_start_runs: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      start_vec[g] |=> ch_run[g]) else $error("started generator not running");
    chk_chain_restart: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      ch_done[g] |=> (ch_run & $past(rstmask_q[g][NUM_CH-1:0]) & $past(en_d)) ==
      ($past(rstmask_q[g][NUM_CH-1:0]) & $past(en_d)))
      else $error("chained restart missing");
    chk_pin_mux: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      ##1 PIN_OUT[g] == ($past(altfn_q[g]) ? $past(ch_out[g]) : $past(GPIO_OUT[g])))
      else $error("pin mux wrong");
    chk_cfg_isolated: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !(wr_do && is_ch(aw_addr_q) && ch_idx(aw_addr_q) == 8'(g)) |=>
      $stable(cfg_q[g]) && $stable(pat_q[g]) && $stable(loops_q[g]))
      else $error("configuration changed by a foreign write");
  end

  // gpio values come from logic on this clock and need no synchroniser
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pin_q <= '0;
    end else begin
      pin_q <= (altfn_q & ch_out) | (~altfn_q & GPIO_OUT);
    end
  end

  // ---- axi4-lite read side
  always_comb begin
    rd_data = 32'h0;
    rd_ok   = 1'b1;
    case ({ARADDR[11:2], 2'b00})
      pte_pkg::OFF_ENABLE:  rd_data[NUM_CH-1:0] = enable_q;
      pte_pkg::OFF_CLKSEL:  rd_data[0] = clksel_q;
      pte_pkg::OFF_DONE:    rd_data[NUM_CH-1:0] = done_q;
      pte_pkg::OFF_ALTFN:   rd_data[NUM_CH-1:0] = altfn_q;
      pte_pkg::OFF_RUNNING: rd_data[NUM_CH-1:0] = ch_run;
      pte_pkg::OFF_START, pte_pkg::OFF_STOP: rd_data = 32'h0;
      default: begin
        rd_ok = is_ch(ARADDR);
        for (int i = 0; i < NUM_CH; i++) begin
          if (rd_ok && ch_idx(ARADDR) == 8'(i)) begin
            case (ARADDR[3:2])
              pte_pkg::FLD_CFG:     rd_data = cfg_q[i];
              pte_pkg::FLD_PATTERN: rd_data = pat_q[i];
              pte_pkg::FLD_LOOPS:   rd_data = loops_q[i];
              default:              rd_data = rstmask_q[i];
            endcase
          end
        end
      end
    endcase
  end

  assign ar_take = ARVALID && arready_q;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= pte_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data;
      rresp_q   <= rd_ok ? pte_pkg::RESP_OKAY : pte_pkg::RESP_SLVERR;
    end else if (rvalid_q && RREADY) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  chk_write_resp: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    aw_take && w_take && !bvalid_q |=> ##1 bvalid_q) else $error("write not answered");
  chk_read_resp: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ar_take |=> rvalid_q && !arready_q) else $error("read not answered");
  chk_bus_clock: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !clksel_q |-> tick) else $error("bus clock selected but no advance");

  assign PIN_OUT = pin_q;
  assign AWREADY = awready_q;
  assign WREADY  = wready_q;
  assign BVALID  = bvalid_q;
  assign BRESP   = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID  = rvalid_q;
  assign RDATA   = rdata_q;
  assign RRESP   = rresp_q;
endmodule

// ==== bench/pulse_train_engine_tb.sv ====
module pulse_train_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("Error %s expected %h got %h", nm, e, g); end end
  logic        REF_CLK = 1'b0;
  logic        RST_N   = 1'b0;
  logic        ALT_CLK = 1'b0;
  logic [1:0]  GPIO_OUT = 2'h0;
  logic [1:0]  PIN_OUT;
  logic [11:0] AWADDR = 12'h0, ARADDR = 12'h0;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [3:0]  WSTRB = 4'hf;
  logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0]  BRESP, RRESP;
  logic [95:0] t0, t1;
  int          err_count = 0, compares = 0, k0, k1;
  logic [31:0] cf[5];
  logic [15:0] lp[5];
  logic [23:0] ex[5];
  logic        fin[5];

  pulse_train_engine #(.NUM_CH(2)) dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .ALT_CLK(ALT_CLK),
    .GPIO_OUT(GPIO_OUT), .PIN_OUT(PIN_OUT), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));

  always #2.5 REF_CLK = ~REF_CLK;
  // alternate source well below half the module clock, phase unrelated
  always #21.3 ALT_CLK = ~ALT_CLK;

  task automatic finish_test();
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] cfg(logic [1:0] m, logic [4:0] l, logic [3:0] r);
    return {12'h0, r, 3'h0, l, 6'h0, m};
  endfunction

  function automatic logic [11:0] ca(int ch, logic [1:0] f);
    return pte_pkg::OFF_CH_BASE + 12'(ch << pte_pkg::CH_SHIFT) + {8'h0, f, 2'h0};
  endfunction

  function automatic int first1(logic [95:0] v);
    for (int i = 0; i < 64; i++) if (v[i] === 1'b1) return i;
    return 64;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    @(posedge REF_CLK);
    AWADDR <= a; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && n < 100);
    BREADY <= 1'b0;
    if (n >= 100) begin err_count++; finish_test(); end
    else `CHK("bresp", er, BRESP)
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
    int n;
    @(posedge REF_CLK);
    ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && n < 100);
    RREADY <= 1'b0;
    if (n >= 100) begin err_count++; finish_test(); end
    else begin
      `CHK("rresp", er, RRESP)
      `CHK("rdata", ed, RDATA)
    end
  endtask

  task automatic setch(int ch, logic [31:0] c, logic [31:0] p, logic [15:0] l);
    wr(ca(ch, pte_pkg::FLD_CFG), c);
    wr(ca(ch, pte_pkg::FLD_PATTERN), p);
    wr(ca(ch, pte_pkg::FLD_LOOPS), {16'h0, l});
  endtask

  // samples at the falling edge so both channels are settled
  task automatic cap();
    t0 = '0;
    t1 = '0;
    for (int i = 0; i < 64; i++) begin
      @(negedge REF_CLK);
      t0[i] = PIN_OUT[0];
      t1[i] = PIN_OUT[1];
    end
  endtask

  initial begin
    // last entry repeats its pattern without end until disabled
    cf  = '{cfg(2, 3, 0), cfg(1, 3, 0), cfg(2, 3, 1), cfg(0, 3, 0), cfg(1, 3, 0)};
    lp  = '{16'h0, 16'h2, 16'h0, 16'h0, 16'h0};
    ex  = '{24'h0000f3, 24'h00f3f3, 24'h00ff0f, 24'h333333, 24'hf3f3f3};
    fin = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    repeat (20) @(posedge REF_CLK);
    RST_N <= 1'b1;
    rd(ca(0, pte_pkg::FLD_CFG), pte_pkg::RST_CFG);
    rd(pte_pkg::OFF_ALTFN, 32'h0);
    rd(12'h3fc, 32'h0, pte_pkg::RESP_SLVERR);
    wr(12'h3fc, 32'hffff_ffff, pte_pkg::RESP_SLVERR);
    GPIO_OUT <= 2'h2;
    repeat (3) @(posedge REF_CLK);
    `CHK("gpio_pass", 2'h2, PIN_OUT)
    wr(pte_pkg::OFF_ALTFN, 32'h3);
    setch(0, cfg(2, 3, 0), 32'hd, 16'h0);
    rd(ca(1, pte_pkg::FLD_CFG), pte_pkg::RST_CFG);
    for (int i = 0; i < 5; i++) begin
      setch(0, cf[i], 32'hd, lp[i]);
      wr(pte_pkg::OFF_ENABLE, 32'h0);
      wr(pte_pkg::OFF_DONE, 32'h3);
      wr(pte_pkg::OFF_ENABLE, 32'h1);
      cap();
      k0 = first1(t0);
      `CHK("wave", ex[i], t0[k0+:24])
      rd(pte_pkg::OFF_DONE, {31'h0, fin[i]});
      rd(pte_pkg::OFF_RUNNING, {31'h0, !fin[i]});
    end
    wr(pte_pkg::OFF_ENABLE, 32'h0);
    repeat (8) @(posedge REF_CLK);
    `CHK("stopped_out", 1'b0, PIN_OUT[0])
    rd(pte_pkg::OFF_RUNNING, 32'h0);
    setch(0, cf[0], 32'hd, 16'h0);
    setch(1, cf[0], 32'hd, 16'h0);
    wr(pte_pkg::OFF_ENABLE, 32'h3);
    repeat (20) @(posedge REF_CLK);
    wr(pte_pkg::OFF_START, 32'h3);
    cap();
    `CHK("group_sync", t0, t1)
    `CHK("group_wave", 8'hf3, t1[first1(t1)+:8])
    wr(ca(0, pte_pkg::FLD_RESTART), 32'h2);
    wr(pte_pkg::OFF_START, 32'h1);
    cap();
    k0 = first1(t0);
    k1 = first1(t1);
    `CHK("chain_gap", 1'b1, (k1 >= k0 + 8 && k1 <= k0 + 10))
    `CHK("chain_wave", 8'hf3, t1[k1+:8])
    wr(pte_pkg::OFF_CLKSEL, 32'h1);
    setch(0, cf[3], 32'h0, 16'h0);
    wr(pte_pkg::OFF_ENABLE, 32'h0);
    wr(pte_pkg::OFF_ENABLE, 32'h1);
    cap();
    // two slow ticks per bit keep the first half period far above six cycles
    `CHK("alt_rate", 6'h3f, t0[first1(t0)+:6])
    finish_test();
  end
endmodule
